// ### otp_link_if.sv
// pin-level link between the otp store and its external programmer
`timescale 1ns/1ps
`default_nettype none
interface otp_link_if;
  logic        rst_pin;
  logic        program_store_enable_pin;
  logic        latch_program_strobe_pin;
  logic        external_access_supply_pin;
  logic        supply_high;
  logic [15:0] address;
  logic        port2_bit7;
  logic        port2_bit6;
  logic        port3_bit7;
  logic        port3_bit6;
  logic        port3_bit3;
  logic [7:0]  port0_dev_out;
  logic        port0_dev_oe_n;
  logic [7:0]  port0_host_out;
  logic        port0_host_oe_n;
  logic [7:0]  port0;

  // external pull-ups give all ones when nobody drives
  assign port0 = !port0_dev_oe_n ? port0_dev_out :
                 (!port0_host_oe_n ? port0_host_out : 8'hFF);

  modport device (
    input  rst_pin, program_store_enable_pin, latch_program_strobe_pin,
    input  external_access_supply_pin, supply_high, address,
    input  port2_bit7, port2_bit6, port3_bit7, port3_bit6, port3_bit3, port0,
    output port0_dev_out, port0_dev_oe_n
  );

  modport programmer (
    output rst_pin, program_store_enable_pin, latch_program_strobe_pin,
    output external_access_supply_pin, supply_high, address,
    output port2_bit7, port2_bit6, port3_bit7, port3_bit6, port3_bit3,
    output port0_host_out, port0_host_oe_n,
    input  port0
  );
endinterface
`default_nettype wire

// ### otp_map.svh
// offsets, field positions, reset values and timing counts of the otp programming link
`ifndef OTP_MAP_SVH
`define OTP_MAP_SVH

`define OTP_CLK_HZ            40000000
`define OTP_OSC_MIN_HZ        4000000
`define OTP_OSC_PERIODS       48
`define OTP_PULSE_COUNT       5
`define OTP_PULSE_US          100
`define OTP_GAP_US            10
`define OTP_VPP_SETUP_US      10
`define OTP_VPP_HOLD_US       10
`define OTP_US_CYC(us)        ((us) * (`OTP_CLK_HZ / 1000000))
`define OTP_OSC_CYC           ((`OTP_OSC_PERIODS * `OTP_CLK_HZ + `OTP_OSC_MIN_HZ - 1) / `OTP_OSC_MIN_HZ)

`define OTP_CODE_BYTES        4096
`define OTP_ENC_BYTES         64
`define OTP_ERASED_BYTE       8'hFF
`define OTP_ID_MAKER_ADDR     16'h0030
`define OTP_ID_PART_ADDR      16'h0031
`define OTP_CLK_BIT           4
`define OTP_LOCK1_BIT         7
`define OTP_LOCK2_BIT         6
`define OTP_LOCK3_BIT         3

`define OTP_REG_CTRL          8'h00
`define OTP_REG_ADDR          8'h04
`define OTP_REG_DATA          8'h08
`define OTP_REG_STATUS        8'h0C
`define OTP_CTRL_GO_BIT       31
`define OTP_STAT_BUSY_BIT     0
`define OTP_STAT_DONE_BIT     1
`define OTP_STAT_DATA_LSB     8

`endif

// ### otp_pkg.sv
// types of the otp programming link: the mode shared by both ends, and the programmer's state
package otp_pkg;
  typedef enum logic [3:0] {
    OTP_NONE, OTP_PGM_CODE, OTP_PGM_ENC, OTP_PGM_LOCK1, OTP_PGM_LOCK2, OTP_PGM_LOCK3,
    OTP_PGM_CLK6, OTP_VFY_CODE, OTP_VFY_ID, OTP_VFY_CLK, OTP_VFY_LOCK
  } otp_mode_t;

  typedef enum logic [2:0] {
    OTP_H_IDLE, OTP_H_SETUP, OTP_H_VPP_UP, OTP_H_LOW, OTP_H_HIGH, OTP_H_VPP_DOWN, OTP_H_HOLD
  } otp_host_state_t;
endpackage

// ### otp_prog_chk.sv
// concurrent checks on the otp programming link
`timescale 1ns/1ps
`default_nettype none
module otp_prog_chk #(
  parameter logic [7:0] MAKER_CODE = 8'h3C,
  parameter logic [7:0] PART_CODE  = 8'h5A
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        supply_high,
  input wire logic        latch_program_strobe_pin,
  input wire logic [15:0] address,
  input wire logic        port2_bit7,
  input wire logic        port2_bit6,
  input wire logic        port3_bit7,
  input wire logic        port3_bit6,
  input wire logic        port3_bit3,
  input wire logic [7:0]  port0_dev_out,
  input wire logic        port0_dev_oe_n
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic rd_v;
  // strobe high, supply off, enable and port2_bit6 low: some verify pattern
  assign rd_v = !supply_high && latch_program_strobe_pin && !port2_bit7 && !port2_bit6;

  // three samples cover the device's input sampling flop
  sequence held_s(x);
    x [*3];
  endsequence

  verify_drive_a: assert property (
    held_s(rd_v && port3_bit7 && port3_bit6) |-> !port0_dev_oe_n)
    else $error("port0 not driven in code verify");
  enable_release_a: assert property ($rose(port2_bit7) |-> ##[1:2] port0_dev_oe_n)
    else $error("port0 not released after enable rose");
  pgm_quiet_a: assert property (held_s(supply_high) |-> port0_dev_oe_n)
    else $error("device drives port0 while programming");
  maker_code_a: assert property (
    held_s(rd_v && !port3_bit7 && !port3_bit6 && address == 16'h0030)
    |-> port0_dev_out == MAKER_CODE)
    else $error("maker code wrong");
  part_code_a: assert property (
    held_s(rd_v && !port3_bit7 && !port3_bit6 && address == 16'h0031)
    |-> port0_dev_out == PART_CODE)
    else $error("part code wrong");
  clk_bits_a: assert property (
    held_s(rd_v && !port3_bit7 && port3_bit6 && port3_bit3)
    |-> (port0_dev_out | 8'h10) == 8'hFF)
    else $error("clock verify other bits not high");
  addr_stable_a: assert property (supply_high |-> $stable(address))
    else $error("address moved under supply");
  strobe_supply_a: assert property (!latch_program_strobe_pin |-> supply_high)
    else $error("strobe low without supply");
endmodule
`default_nettype wire

// ### otp_prog_device.sv
// otp code store end: program, verify, identification and lock logic
// Overview of operation
// - programmer gives five strobe lows under supply
// - strobe low 90 to 110 us, gap 10
// - address and data held 48 periods around strobe
// - verify data out within 48 periods of address
// - port0 driven and released within 48 periods
// - clock-mode programming needs its own pin pattern
// - clock-mode verify shows bit on port0_bit4
// - lock verify shows bits on 7, 6, 3
// - unlocked code verifies, still encrypted
// - lock one blocks table reads, programming; latches access
// - lock two adds verify disable
// - lock three: no external execution, no ram
// - other lock combinations are undefined
// - encryption array starts all ones
// - lock two and three disable verify
// - mask image layout: code, key, lock byte
// - verify data is code xnor key byte
// - identification read at 030h and 031h
// - lock two only accepted after lock one
`timescale 1ns/1ps
`default_nettype none
`include "otp_map.svh"
module otp_prog_device import otp_pkg::*; #(
  parameter int         CODE_DEPTH = `OTP_CODE_BYTES,
  parameter int         ENC_DEPTH  = `OTP_ENC_BYTES,
  parameter logic [7:0] MAKER_CODE = 8'h3C,  // arbitrary value
  parameter logic [7:0] PART_CODE  = 8'h5A   // arbitrary value
) (
  input  wire logic   hclk,
  input  wire logic   hresetn,
  otp_link_if.device  link,
  output logic        clock_mode_12x,
  output logic [2:0]  lock_bits,
  output logic        table_read_block,
  output logic        external_access_eff,
  output logic        verify_disable,
  output logic        external_exec_disable,
  output logic        data_ram_disable
);
  localparam int CA = $clog2(CODE_DEPTH);
  localparam int EA = $clog2(ENC_DEPTH);

  function automatic otp_mode_t decode_mode(
    input logic       vpp,
    input logic       ea,
    input logic       strobe,
    input logic [4:0] sel
  );
    decode_mode = OTP_NONE;
    if (vpp)
    begin
      casez (sel)
        5'b1011?: decode_mode = OTP_PGM_CODE;
        5'b1010?: decode_mode = OTP_PGM_ENC;
        5'b1111?: decode_mode = OTP_PGM_LOCK1;
        5'b1100?: decode_mode = OTP_PGM_LOCK2;
        5'b0101?: decode_mode = OTP_PGM_LOCK3;
        5'b00100: decode_mode = OTP_PGM_CLK6;
        default:  decode_mode = OTP_NONE;
      endcase
    end
    else if (ea && strobe)
    begin
      // port2_bit7 is the output enable in verify modes, so it is left out here
      casez (sel)
        5'b?011?: decode_mode = OTP_VFY_CODE;
        5'b?000?: decode_mode = OTP_VFY_ID;
        5'b?0011: decode_mode = OTP_VFY_CLK;
        5'b?010?: decode_mode = OTP_VFY_LOCK;
        default:  decode_mode = OTP_NONE;
      endcase
    end
  endfunction

  function automatic logic is_pgm(input otp_mode_t m);
    is_pgm = m inside {OTP_PGM_CODE, OTP_PGM_ENC, OTP_PGM_LOCK1, OTP_PGM_LOCK2,
                       OTP_PGM_LOCK3, OTP_PGM_CLK6};
  endfunction

  logic [7:0]    code_q [CODE_DEPTH];
  logic [7:0]    code_d [CODE_DEPTH];
  logic [7:0]    enc_q  [ENC_DEPTH];
  logic [7:0]    enc_d  [ENC_DEPTH];
  logic [2:0]    lock_q, lock_d;
  logic          clk12_q, clk12_d;
  logic          strobe_q, strobe_d;
  logic          rstpin_q, rstpin_d;
  logic          ealatch_q, ealatch_d;
  logic [2:0]    pulses_q, pulses_d;
  logic [15:0]   addr_q, addr_d;
  logic [7:0]    data_q, data_d;
  otp_mode_t     pmode_q, pmode_d;
  logic [7:0]    p0_q, p0_d;
  logic          oe_n_q, oe_n_d;
  logic [5:0]    prot_q, prot_d;
  otp_mode_t     mode;
  logic          active;
  logic          lock_any;
  logic          vfy_off;
  logic [CA-1:0] vidx;
  logic [EA-1:0] veidx;

  assign active   = link.rst_pin && !link.program_store_enable_pin;
  assign mode     = active ? decode_mode(link.supply_high, link.external_access_supply_pin,
                                         link.latch_program_strobe_pin,
                                         {link.port2_bit7, link.port2_bit6, link.port3_bit7,
                                          link.port3_bit6, link.port3_bit3})
                           : OTP_NONE;
  // undefined lock combinations get the restrictions of the highest bit that is set and of every level below it
  assign lock_any = |lock_q;
  assign vfy_off  = lock_q[1] | lock_q[2];
  assign vidx     = link.address[CA-1:0];
  assign veidx    = link.address[EA-1:0];

  // programming: capture at strobe fall, count rises, commit on the last
  always_comb
  begin
    code_d    = code_q;
    enc_d     = enc_q;
    lock_d    = lock_q;
    clk12_d   = clk12_q;
    strobe_d  = link.latch_program_strobe_pin;
    addr_d    = addr_q;
    data_d    = data_q;
    pmode_d   = pmode_q;
    pulses_d  = pulses_q;
    if (!is_pgm(mode))
    begin
      pulses_d = 3'h0;
    end
    else if (!link.latch_program_strobe_pin && strobe_q)
    begin
      addr_d  = link.address;
      data_d  = link.port0;
      pmode_d = mode;
    end
    else if (link.latch_program_strobe_pin && !strobe_q)
    begin
      if (pulses_q == 3'(`OTP_PULSE_COUNT - 1))
      begin
        pulses_d = 3'h0;
        case (pmode_q)
          // a cell only goes from one to zero, like a real otp bit
          OTP_PGM_CODE:
            if (!lock_any)
              code_d[addr_q[CA-1:0]] = code_q[addr_q[CA-1:0]] & data_q;
          OTP_PGM_ENC:
            if (!lock_any)
              enc_d[addr_q[EA-1:0]] = enc_q[addr_q[EA-1:0]] & data_q;
          OTP_PGM_LOCK1: lock_d[0] = 1'b1;
          OTP_PGM_LOCK2:
            if (lock_q[0])
              lock_d[1] = 1'b1;
          OTP_PGM_LOCK3: lock_d[2] = 1'b1;
          OTP_PGM_CLK6:
            if (!lock_any)
              clk12_d = 1'b0;
          default: pulses_d = 3'h0;
        endcase
      end
      else
      begin
        pulses_d = pulses_q + 3'h1;
      end
    end
  end

  // verify path: registered, so port0 follows address or enable in one cycle
  always_comb
  begin
    p0_d   = `OTP_ERASED_BYTE;
    oe_n_d = 1'b1;
    if (!link.port2_bit7)
    begin
      case (mode)
        OTP_VFY_CODE:
        begin
          oe_n_d = 1'b0;
          if (!vfy_off)
            p0_d = ~(code_q[vidx] ^ enc_q[veidx]);
        end
        OTP_VFY_ID:
        begin
          oe_n_d = 1'b0;
          if (link.address == `OTP_ID_MAKER_ADDR)
            p0_d = MAKER_CODE;
          else if (link.address == `OTP_ID_PART_ADDR)
            p0_d = PART_CODE;
        end
        OTP_VFY_CLK:
        begin
          oe_n_d = 1'b0;
          p0_d[`OTP_CLK_BIT] = clk12_q;
        end
        OTP_VFY_LOCK:
        begin
          oe_n_d = 1'b0;
          // a programmed lock bit reads as zero
          p0_d[`OTP_LOCK1_BIT] = ~lock_q[0];
          p0_d[`OTP_LOCK2_BIT] = ~lock_q[1];
          p0_d[`OTP_LOCK3_BIT] = ~lock_q[2];
        end
        default: oe_n_d = 1'b1;
      endcase
    end
  end

  // protection levels and the access pin caught when reset is released
  always_comb
  begin
    rstpin_d  = link.rst_pin;
    ealatch_d = ealatch_q;
    if (rstpin_q && !link.rst_pin)
      ealatch_d = link.external_access_supply_pin;
    prot_d = {lock_any ? ealatch_q : link.external_access_supply_pin,
              lock_any,
              vfy_off,
              lock_q[2],
              lock_q[2],
              clk12_q};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < CODE_DEPTH; i++)
        code_q[i] <= `OTP_ERASED_BYTE;
      for (int i = 0; i < ENC_DEPTH; i++)
        enc_q[i] <= `OTP_ERASED_BYTE;
      lock_q    <= 3'h0;
      clk12_q   <= 1'b1;
      strobe_q  <= 1'b1;
      rstpin_q  <= 1'b0;
      ealatch_q <= 1'b1;
      pulses_q  <= 3'h0;
      addr_q    <= 16'h0000;
      data_q    <= 8'hFF;
      pmode_q   <= OTP_NONE;
      p0_q      <= 8'hFF;
      oe_n_q    <= 1'b1;
      prot_q    <= 6'h21;
    end
    else
    begin
      code_q    <= code_d;
      enc_q     <= enc_d;
      lock_q    <= lock_d;
      clk12_q   <= clk12_d;
      strobe_q  <= strobe_d;
      rstpin_q  <= rstpin_d;
      ealatch_q <= ealatch_d;
      pulses_q  <= pulses_d;
      addr_q    <= addr_d;
      data_q    <= data_d;
      pmode_q   <= pmode_d;
      p0_q      <= p0_d;
      oe_n_q    <= oe_n_d;
      prot_q    <= prot_d;
    end
  end

  assign link.port0_dev_out  = p0_q;
  assign link.port0_dev_oe_n = oe_n_q;
  assign external_access_eff   = prot_q[5];
  assign table_read_block      = prot_q[4];
  assign verify_disable        = prot_q[3];
  assign external_exec_disable = prot_q[2];
  assign data_ram_disable      = prot_q[1];
  assign clock_mode_12x        = prot_q[0];
  assign lock_bits             = lock_q;
endmodule
`default_nettype wire

// ### otp_prog_programmer.sv
// external programmer end: ahb-lite command registers driving the otp pins
`timescale 1ns/1ps
`default_nettype none
`include "otp_map.svh"
module otp_prog_programmer import otp_pkg::*; #(
  parameter logic [15:0] OSC_CYC   = 16'(`OTP_OSC_CYC),
  parameter logic [15:0] PULSE_CYC = 16'(`OTP_US_CYC(`OTP_PULSE_US)),
  parameter logic [15:0] GAP_CYC   = 16'(`OTP_US_CYC(`OTP_GAP_US)),
  parameter logic [15:0] VSU_CYC   = 16'(`OTP_US_CYC(`OTP_VPP_SETUP_US)),
  parameter logic [15:0] VHO_CYC   = 16'(`OTP_US_CYC(`OTP_VPP_HOLD_US))
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  otp_link_if.programmer   link
);
  // {port2_bit7, port2_bit6, port3_bit7, port3_bit6, port3_bit3}
  function automatic logic [4:0] mode_pins(input otp_mode_t m);
    case (m)
      OTP_PGM_CODE:  mode_pins = 5'h17;
      OTP_PGM_ENC:   mode_pins = 5'h15;
      OTP_PGM_LOCK1: mode_pins = 5'h1F;
      OTP_PGM_LOCK2: mode_pins = 5'h19;
      OTP_PGM_LOCK3: mode_pins = 5'h0B;
      OTP_PGM_CLK6:  mode_pins = 5'h04;
      OTP_VFY_CODE:  mode_pins = 5'h07;
      OTP_VFY_ID:    mode_pins = 5'h01;
      OTP_VFY_CLK:   mode_pins = 5'h03;
      OTP_VFY_LOCK:  mode_pins = 5'h05;
      default:       mode_pins = 5'h1F;
    endcase
  endfunction

  function automatic logic is_pgm(input otp_mode_t m);
    is_pgm = m inside {OTP_PGM_CODE, OTP_PGM_ENC, OTP_PGM_LOCK1, OTP_PGM_LOCK2,
                       OTP_PGM_LOCK3, OTP_PGM_CLK6};
  endfunction

  // idle pattern: enable high and no verify code, so the store never drives
  localparam logic [4:0] IDLE_PINS = 5'h1F;

  otp_host_state_t state_q, state_d;
  logic [15:0] cnt_q, cnt_d;
  logic [2:0]  pulses_q, pulses_d;
  otp_mode_t   mode_q, mode_d;
  logic [15:0] addr_q, addr_d;
  logic [7:0]  data_q, data_d;
  logic [7:0]  rsp_q, rsp_d;
  logic        done_q, done_d;
  logic [4:0]  pins_q, pins_d;
  logic        strobe_q, strobe_d;
  logic        vpp_q, vpp_d;
  logic        p0oe_n_q, p0oe_n_d;
  logic        wr_q, wr_d;
  logic [7:0]  waddr_q, waddr_d;
  logic [31:0] rdata_q, rdata_d;
  logic        go;
  logic        done_set;
  logic        take;

  assign take = hsel && hready && htrans[1];

  // bus side: zero wait states, writes land at the end of their data phase
  always_comb
  begin
    wr_d    = take && hwrite;
    waddr_d = haddr[7:0];
    rdata_d = 32'h0000_0000;
    if (take && !hwrite)
    begin
      case (haddr[7:0])
        `OTP_REG_CTRL:   rdata_d = {28'h000_0000, mode_q};
        `OTP_REG_ADDR:   rdata_d = {16'h0000, addr_q};
        `OTP_REG_DATA:   rdata_d = {24'h00_0000, data_q};
        `OTP_REG_STATUS: rdata_d = {16'h0000, rsp_q, 6'h00, done_q, state_q != OTP_H_IDLE};
        default:         rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // sequencer for the strobe train and the verify sample
  always_comb
  begin
    go       = wr_q && waddr_q == `OTP_REG_CTRL && hwdata[`OTP_CTRL_GO_BIT];
    state_d  = state_q;
    cnt_d    = cnt_q;
    pulses_d = pulses_q;
    mode_d   = mode_q;
    addr_d   = addr_q;
    data_d   = data_q;
    rsp_d    = rsp_q;
    pins_d   = pins_q;
    strobe_d = strobe_q;
    vpp_d    = vpp_q;
    p0oe_n_d = p0oe_n_q;
    done_set = 1'b0;
    if (wr_q && state_q == OTP_H_IDLE)
    begin
      if (waddr_q == `OTP_REG_CTRL)
        mode_d = (hwdata[3:0] <= 4'(OTP_VFY_LOCK)) ? otp_mode_t'(hwdata[3:0]) : OTP_NONE;
      if (waddr_q == `OTP_REG_ADDR)
        addr_d = hwdata[15:0];
      if (waddr_q == `OTP_REG_DATA)
        data_d = hwdata[7:0];
    end
    case (state_q)
      OTP_H_IDLE:
        if (go && mode_d != OTP_NONE)
        begin
          state_d  = OTP_H_SETUP;
          cnt_d    = OSC_CYC;
          pulses_d = 3'h0;
          pins_d   = mode_pins(mode_d);
          p0oe_n_d = !is_pgm(mode_d);
        end
      OTP_H_SETUP:
        if (cnt_q != 16'h0000)
          cnt_d = cnt_q - 16'h0001;
        else if (is_pgm(mode_q))
        begin
          state_d = OTP_H_VPP_UP;
          vpp_d   = 1'b1;
          cnt_d   = VSU_CYC;
        end
        else
        begin
          rsp_d   = link.port0;
          state_d = OTP_H_HOLD;
          pins_d  = IDLE_PINS;
          cnt_d   = OSC_CYC;
        end
      OTP_H_VPP_UP, OTP_H_HIGH:
        if (cnt_q != 16'h0000)
          cnt_d = cnt_q - 16'h0001;
        else
        begin
          state_d  = OTP_H_LOW;
          strobe_d = 1'b0;
          cnt_d    = PULSE_CYC;
        end
      OTP_H_LOW:
        if (cnt_q != 16'h0000)
          cnt_d = cnt_q - 16'h0001;
        else
        begin
          strobe_d = 1'b1;
          pulses_d = pulses_q + 3'h1;
          if (pulses_q == 3'(`OTP_PULSE_COUNT - 1))
          begin
            state_d = OTP_H_VPP_DOWN;
            cnt_d   = VHO_CYC;
          end
          else
          begin
            state_d = OTP_H_HIGH;
            cnt_d   = GAP_CYC;
          end
        end
      OTP_H_VPP_DOWN:
        if (cnt_q != 16'h0000)
          cnt_d = cnt_q - 16'h0001;
        else
        begin
          vpp_d   = 1'b0;
          state_d = OTP_H_HOLD;
          cnt_d   = OSC_CYC;
        end
      OTP_H_HOLD:
        if (cnt_q != 16'h0000)
          cnt_d = cnt_q - 16'h0001;
        else
        begin
          pins_d   = IDLE_PINS;
          p0oe_n_d = 1'b1;
          done_set = 1'b1;
          state_d  = OTP_H_IDLE;
        end
      default: state_d = OTP_H_IDLE;
    endcase
    // set wins over a clear written in the same cycle
    done_d = done_set | (done_q & ~(wr_q && waddr_q == `OTP_REG_STATUS &&
                                   hwdata[`OTP_STAT_DONE_BIT]));
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q  <= OTP_H_IDLE;
      cnt_q    <= 16'h0000;
      pulses_q <= 3'h0;
      mode_q   <= OTP_NONE;
      addr_q   <= 16'h0000;
      data_q   <= 8'hFF;
      rsp_q    <= 8'h00;
      done_q   <= 1'b0;
      pins_q   <= IDLE_PINS;
      strobe_q <= 1'b1;
      vpp_q    <= 1'b0;
      p0oe_n_q <= 1'b1;
      wr_q     <= 1'b0;
      waddr_q  <= 8'h00;
      rdata_q  <= 32'h0000_0000;
    end
    else
    begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      pulses_q <= pulses_d;
      mode_q   <= mode_d;
      addr_q   <= addr_d;
      data_q   <= data_d;
      rsp_q    <= rsp_d;
      done_q   <= done_d;
      pins_q   <= pins_d;
      strobe_q <= strobe_d;
      vpp_q    <= vpp_d;
      p0oe_n_q <= p0oe_n_d;
      wr_q     <= wr_d;
      waddr_q  <= waddr_d;
      rdata_q  <= rdata_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;
  assign link.rst_pin                    = 1'b1;
  assign link.program_store_enable_pin   = 1'b0;
  assign link.external_access_supply_pin = 1'b1;
  assign link.latch_program_strobe_pin   = strobe_q;
  assign link.supply_high                = vpp_q;
  assign link.address                    = addr_q;
  assign {link.port2_bit7, link.port2_bit6, link.port3_bit7, link.port3_bit6,
          link.port3_bit3} = pins_q;
  assign link.port0_host_out             = data_q;
  assign link.port0_host_oe_n            = p0oe_n_q;
endmodule
`default_nettype wire

// ### otp_program_verify_control_tb.sv
// self-checking bench: both otp ends joined, driven over ahb-lite
`timescale 1ns/1ps
`default_nettype none
`include "otp_map.svh"
module otp_program_verify_control_tb import otp_pkg::*; ;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [2:0]  lock_bits;
  logic        clk12;
  logic [4:0]  flags;
  logic [31:0] rd;
  logic [7:0]  vd;
  int          num_errors;
  int          n_checks;

  otp_link_if lnk ();
  otp_prog_device otp_prog_device_i (.hclk(hclk), .hresetn(hresetn), .link(lnk.device),
    .clock_mode_12x(clk12), .lock_bits(lock_bits), .table_read_block(flags[0]),
    .external_access_eff(flags[4]), .verify_disable(flags[1]), .external_exec_disable(flags[2]),
    .data_ram_disable(flags[3]));
  // short counts keep each program sequence near 140 cycles
  otp_prog_programmer #(.OSC_CYC(16'h0004), .PULSE_CYC(16'h0014), .GAP_CYC(16'h0003),
    .VSU_CYC(16'h0003), .VHO_CYC(16'h0003)) otp_prog_programmer_i (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .link(lnk.programmer));
  otp_prog_chk otp_prog_chk_i (.hclk(hclk), .hresetn(hresetn), .supply_high(lnk.supply_high),
    .latch_program_strobe_pin(lnk.latch_program_strobe_pin), .address(lnk.address),
    .port2_bit7(lnk.port2_bit7), .port2_bit6(lnk.port2_bit6), .port3_bit7(lnk.port3_bit7),
    .port3_bit6(lnk.port3_bit6), .port3_bit3(lnk.port3_bit3),
    .port0_dev_out(lnk.port0_dev_out), .port0_dev_oe_n(lnk.port0_dev_oe_n));

  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic edge_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
    begin
      num_errors++;
      conclude();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    edge_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    edge_rdy();
    rd = hrdata;
  endtask

  // one full link operation; verify data is kept in vd before done is cleared
  task automatic op(input otp_mode_t m, input logic [15:0] a, input logic [7:0] d);
    int n;
    bus(1'b1, `OTP_REG_ADDR, {16'h0, a});
    bus(1'b1, `OTP_REG_DATA, {24'h0, d});
    bus(1'b1, `OTP_REG_CTRL, {1'b1, 27'h0, m});
    n = 0;
    do
    begin
      bus(1'b0, `OTP_REG_STATUS, 32'h0);
      n++;
    end
    while (rd[`OTP_STAT_DONE_BIT] !== 1'b1 && n < 400);
    if (rd[`OTP_STAT_DONE_BIT] !== 1'b1)
    begin
      num_errors++;
      conclude();
    end
    vd = rd[`OTP_STAT_DATA_LSB +: 8];
    bus(1'b1, `OTP_REG_STATUS, 32'h2);
  endtask

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    num_errors = 0;
    n_checks = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("lock_bits", 8'h00, {5'h0, lock_bits});
    chk("reset flags", 8'h10, {3'h0, flags});
    op(OTP_VFY_CODE, 16'h0005, 8'h00);
    chk("erased", 8'hFF, vd);
    op(OTP_PGM_CODE, 16'h0005, 8'hA5);
    op(OTP_VFY_CODE, 16'h0005, 8'h00);
    chk("code", 8'hA5, vd);
    op(OTP_PGM_ENC, 16'h0005, 8'h0F);
    op(OTP_VFY_CODE, 16'h0005, 8'h00);
    chk("encrypted", 8'h55, vd);
    op(OTP_VFY_ID, 16'h0030, 8'h00);
    chk("maker", 8'h3C, vd);
    op(OTP_VFY_ID, 16'h0031, 8'h00);
    chk("part", 8'h5A, vd);
    op(OTP_VFY_CLK, 16'h0000, 8'h00);
    chk("clk 12x", 8'hFF, vd);
    op(OTP_PGM_CLK6, 16'h0000, 8'h00);
    op(OTP_VFY_CLK, 16'h0000, 8'h00);
    chk("clk 6x", 8'hEF, vd);
    chk("clock_mode", 8'h00, {7'h0, clk12});
    op(OTP_PGM_LOCK2, 16'h0000, 8'h00);
    chk("lock two alone", 8'h00, {5'h0, lock_bits});
    op(OTP_PGM_LOCK1, 16'h0000, 8'h00);
    chk("lock one flags", 8'h11, {3'h0, flags});
    op(OTP_PGM_CODE, 16'h0006, 8'h00);
    op(OTP_VFY_CODE, 16'h0006, 8'h00);
    chk("pgm refused", 8'hFF, vd);
    op(OTP_PGM_LOCK2, 16'h0000, 8'h00);
    chk("lock two flags", 8'h13, {3'h0, flags});
    chk("lock byte", 8'h03, {5'h0, lock_bits});
    op(OTP_VFY_CODE, 16'h0005, 8'h00);
    chk("verify off", 8'hFF, vd);
    op(OTP_PGM_LOCK3, 16'h0000, 8'h00);
    chk("lock three flags", 8'h1F, {3'h0, flags});
    op(OTP_VFY_LOCK, 16'h0000, 8'h00);
    chk("lock verify", 8'h37, vd);
    chk("hresp", 8'h00, {7'h0, hresp});
    conclude();
  end
endmodule
`default_nettype wire
